// File: verilog/async_static_ram_host.sv
// host controller that runs reads, writes and retention on the static memory
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"

module async_static_ram_host (
	// clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       rst_n_i,
	// access requests
	input  wire logic                       req_valid_i,
	input  wire sram_host_pkg::mem_req_s    req_i,
	output logic                            req_ready_o,
	// read answers and write completion
	output logic                            rsp_valid_o,
	output logic [`SRAM_DATA_W-1:0]         rsp_rdata_o,
	output logic                            wr_done_o,
	// low supply retention handshake
	input  wire logic                       retention_req_i,
	output logic                            retention_ack_o,
	// memory pins
	output sram_host_pkg::sram_pins_s       pins_o,
	input  wire logic [`SRAM_DATA_W-1:0]    shared_data_bus_i
);

	// state timing in cycles
	localparam int unsigned RD_CYC    = cyc_rd();
	localparam int unsigned FLOAT_CYC = `SRAM_HZ_CYC;
	localparam int unsigned WP_CYC    = cyc_wp();
	localparam int unsigned HOLD_CYC  = cyc_hold();
	localparam int unsigned WAKE_CYC  = `SRAM_RC_CYC;

	// read wait covers access time, synchroniser and margin, and the cycle time
	function automatic int unsigned cyc_rd();
		cyc_rd = sram_host_pkg::cyc_max(`SRAM_ACC_CYC + `SRAM_SYNC_STAGES + `SRAM_RD_MARGIN,
			`SRAM_RC_CYC);
	endfunction

	// write pulse long enough for address, select, data and float delay
	function automatic int unsigned cyc_wp();
		cyc_wp = sram_host_pkg::cyc_max(sram_host_pkg::cyc_max(`SRAM_AW_CYC, `SRAM_CW_CYC),
			sram_host_pkg::cyc_max(`SRAM_WP_MIN_CYC, `SRAM_DW_CYC));
	endfunction

	// hold after write end fills the rest of the write cycle, one cycle at least
	function automatic int unsigned cyc_hold();
		cyc_hold = (`SRAM_WC_CYC > cyc_wp() + 1) ? (`SRAM_WC_CYC - cyc_wp()) : 1;
	endfunction

	// registered state
	sram_host_pkg::host_state_e state_ff;
	sram_host_pkg::host_state_e nxt_state;
	sram_host_pkg::sram_pins_s  pins_ff;
	sram_host_pkg::sram_pins_s  nxt_pins;
	logic [`SRAM_DATA_W-1:0]    rdata_ff;
	logic [`SRAM_DATA_W-1:0]    nxt_rdata;
	logic                       rsp_valid_ff;
	logic                       nxt_rsp_valid;
	logic                       wr_done_ff;
	logic                       nxt_wr_done;
	logic                       ret_ack_ff;
	logic                       nxt_ret_ack;

	// timer control
	logic                       tmr_load;
	logic [`SRAM_TMR_W-1:0]     tmr_val;
	logic                       tmr_done;

	// synchronised data pins
	logic [`SRAM_DATA_W-1:0]    data_sync;

	// handshake
	logic                       accept;

	// data bus passes two flip-flops before anything reads it
	host_pin_sync u_data_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (shared_data_bus_i),
		.sync_o  (data_sync)
	);

	// one timer paces every state but idle and retention hold
	host_cycle_timer u_timer (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.load_i     (tmr_load),
		.load_val_i (tmr_val),
		.done_o     (tmr_done)
	);

	// requests only taken when idle and retention is not asked for
	assign req_ready_o = (state_ff == sram_host_pkg::ST_IDLE) && !retention_req_i;
	assign accept      = req_valid_i && req_ready_o;

	// next state, pins and answers
	always_comb begin
		nxt_state     = state_ff;
		nxt_pins      = pins_ff;
		nxt_rdata     = rdata_ff;
		nxt_rsp_valid = 1'b0;
		nxt_wr_done   = 1'b0;
		nxt_ret_ack   = ret_ack_ff;
		tmr_load      = 1'b0;
		tmr_val       = '0;
		unique case (state_ff)
			sram_host_pkg::ST_IDLE: begin
				if (retention_req_i) begin
					// select already high here, so retention may start at once
					nxt_pins.cs_n    = 1'b1;
					nxt_pins.data_oe = 1'b0;
					nxt_ret_ack      = 1'b1;
					nxt_state        = sram_host_pkg::ST_RET_HOLD;
				end else if (accept && req_i.write) begin
					// address, data, select and write enable change together
					nxt_pins.word_address = req_i.addr;
					nxt_pins.data_out     = req_i.wdata;
					nxt_pins.data_oe      = 1'b1;
					nxt_pins.oe_n         = 1'b1;
					nxt_pins.cs_n         = 1'b0;
					nxt_pins.we_n         = 1'b0;
					tmr_load              = 1'b1;
					tmr_val               = sram_host_pkg::tmr_load(WP_CYC);
					nxt_state             = sram_host_pkg::ST_WR_PULSE;
				end else if (accept) begin
					// read: select and output enable low, bus released
					nxt_pins.word_address = req_i.addr;
					nxt_pins.data_oe      = 1'b0;
					nxt_pins.we_n         = 1'b1;
					nxt_pins.oe_n         = 1'b0;
					nxt_pins.cs_n         = 1'b0;
					tmr_load              = 1'b1;
					tmr_val               = sram_host_pkg::tmr_load(RD_CYC);
					nxt_state             = sram_host_pkg::ST_RD_WAIT;
				end
			end
			sram_host_pkg::ST_RD_WAIT: begin
				// address held steady the whole read, sample once access has elapsed
				if (tmr_done) begin
					nxt_rdata     = data_sync;
					nxt_rsp_valid = 1'b1;
					nxt_pins.cs_n = 1'b1;
					nxt_pins.oe_n = 1'b1;
					tmr_load      = 1'b1;
					tmr_val       = sram_host_pkg::tmr_load(FLOAT_CYC);
					nxt_state     = sram_host_pkg::ST_RD_FLOAT;
				end
			end
			sram_host_pkg::ST_RD_FLOAT: begin
				// wait for the memory to let go before the bus may be driven
				if (tmr_done) begin
					nxt_state = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_WR_PULSE: begin
				// select and write enable rise together; the byte is taken now
				if (tmr_done) begin
					nxt_pins.cs_n = 1'b1;
					nxt_pins.we_n = 1'b1;
					tmr_load      = 1'b1;
					tmr_val       = sram_host_pkg::tmr_load(HOLD_CYC);
					nxt_state     = sram_host_pkg::ST_WR_HOLD;
				end
			end
			sram_host_pkg::ST_WR_HOLD: begin
				// data and address stay past write end until the cycle is over
				if (tmr_done) begin
					nxt_pins.data_oe = 1'b0;
					nxt_wr_done      = 1'b1;
					nxt_state        = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_RET_HOLD: begin
				// stay deselected while the supply is low
				nxt_pins.cs_n = 1'b1;
				if (!retention_req_i) begin
					nxt_ret_ack = 1'b0;
					tmr_load    = 1'b1;
					tmr_val     = sram_host_pkg::tmr_load(WAKE_CYC);
					nxt_state   = sram_host_pkg::ST_RET_WAKE;
				end
			end
			sram_host_pkg::ST_RET_WAKE: begin
				// recovery of one read cycle before the next access
				if (tmr_done) begin
					nxt_state = sram_host_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = sram_host_pkg::ST_IDLE;
				nxt_pins.cs_n    = 1'b1;
				nxt_pins.we_n    = 1'b1;
				nxt_pins.oe_n    = 1'b1;
				nxt_pins.data_oe = 1'b0;
			end
		endcase
	end

	// registers only; pins idle deselected with the bus released
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff              <= sram_host_pkg::ST_IDLE;
			pins_ff.word_address  <= '0;
			pins_ff.cs_n          <= 1'b1;
			pins_ff.oe_n          <= 1'b1;
			pins_ff.we_n          <= 1'b1;
			pins_ff.data_out      <= '0;
			pins_ff.data_oe       <= 1'b0;
			rdata_ff              <= '0;
			rsp_valid_ff          <= 1'b0;
			wr_done_ff            <= 1'b0;
			ret_ack_ff            <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			pins_ff      <= nxt_pins;
			rdata_ff     <= nxt_rdata;
			rsp_valid_ff <= nxt_rsp_valid;
			wr_done_ff   <= nxt_wr_done;
			ret_ack_ff   <= nxt_ret_ack;
		end
	end

	// outputs straight from flip-flops; no clock ever goes to the memory
	assign pins_o          = pins_ff;
	assign rsp_valid_o     = rsp_valid_ff;
	assign rsp_rdata_o     = rdata_ff;
	assign wr_done_o       = wr_done_ff;
	assign retention_ack_o = ret_ack_ff;

endmodule // async_static_ram_host

`default_nettype wire

// File: verilog/sram_host_consts.svh
// timing and geometry constants for the static memory host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH

// geometry of the memory
`define SRAM_ADDR_W        19
`define SRAM_DATA_W        8

// controller clock period in ns (200 MHz)
`define SRAM_CLK_PERIOD_NS 5

// timing of the slower speed grade, in ns, used so either grade is safe
`define SRAM_T_RC_NS       70
`define SRAM_T_WC_NS       70
`define SRAM_T_ACC_NS      70
`define SRAM_T_HZ_NS       25
`define SRAM_T_WHZ_NS      25
`define SRAM_T_AW_NS       60
`define SRAM_T_CW_NS       60
`define SRAM_T_WP_NS       50
`define SRAM_T_DW_NS       30
`define SRAM_T_DH_NS       0
`define SRAM_T_WR_NS       0
`define SRAM_T_CDR_NS      0

// least times round up to whole cycles
`define SRAM_CYC_UP(ns)    (((ns) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)

// cycle counts derived from the times above
`define SRAM_RC_CYC        `SRAM_CYC_UP(`SRAM_T_RC_NS)
`define SRAM_WC_CYC        `SRAM_CYC_UP(`SRAM_T_WC_NS)
`define SRAM_ACC_CYC       `SRAM_CYC_UP(`SRAM_T_ACC_NS)
`define SRAM_HZ_CYC        `SRAM_CYC_UP(`SRAM_T_HZ_NS)
`define SRAM_AW_CYC        `SRAM_CYC_UP(`SRAM_T_AW_NS)
`define SRAM_CW_CYC        `SRAM_CYC_UP(`SRAM_T_CW_NS)
`define SRAM_WP_MIN_CYC    `SRAM_CYC_UP(`SRAM_T_WP_NS)
`define SRAM_DW_CYC        `SRAM_CYC_UP(`SRAM_T_DW_NS + `SRAM_T_WHZ_NS)

// data input synchroniser depth and read sampling margin
`define SRAM_SYNC_STAGES   2
`define SRAM_RD_MARGIN     1

// timer width
`define SRAM_TMR_W         8

`endif

// File: verilog/sram_host_pkg.sv
// types and helpers shared by the static memory host controller
`include "sram_host_consts.svh"

package sram_host_pkg;

	// pins driven toward the memory
	typedef struct packed {
		logic [`SRAM_ADDR_W-1:0] word_address;
		logic                    cs_n;
		logic                    oe_n;
		logic                    we_n;
		logic [`SRAM_DATA_W-1:0] data_out;
		logic                    data_oe;
	} sram_pins_s;

	// one access request from the user side
	typedef struct packed {
		logic                    write;
		logic [`SRAM_ADDR_W-1:0] addr;
		logic [`SRAM_DATA_W-1:0] wdata;
	} mem_req_s;

	// controller states, one bit changes per step along read and write paths, except the two-bit return to idle
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_RD_WAIT  = 3'h1,
		ST_RD_FLOAT = 3'h3,
		ST_WR_PULSE = 3'h2,
		ST_WR_HOLD  = 3'h6,
		ST_RET_HOLD = 3'h4,
		ST_RET_WAKE = 3'h5
	} host_state_e;

	// timer load value for a state that lasts n cycles (at least one)
	function automatic logic [`SRAM_TMR_W-1:0] tmr_load(input int unsigned n);
		tmr_load = (n < 1) ? '0 : `SRAM_TMR_W'(n - 1);
	endfunction

	// larger of two cycle counts
	function automatic int unsigned cyc_max(input int unsigned a, input int unsigned b);
		cyc_max = (a > b) ? a : b;
	endfunction

endpackage

// File: verilog/host_pin_sync.sv
// two flip-flop synchroniser for the memory data pins
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"

module host_pin_sync (
	// clock and reset
	input  wire logic                    clock_i,
	input  wire logic                    rst_n_i,
	// asynchronous pin value and its synchronised copy
	input  wire logic [`SRAM_DATA_W-1:0] pin_i,
	output logic      [`SRAM_DATA_W-1:0] sync_o
);

	logic [`SRAM_DATA_W-1:0] meta_ff;
	logic [`SRAM_DATA_W-1:0] sync_ff;
	logic [`SRAM_DATA_W-1:0] nxt_meta;
	logic [`SRAM_DATA_W-1:0] nxt_sync;

	// first stage feeds only the second
	always_comb begin
		nxt_meta = pin_i;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_o = sync_ff;

endmodule // host_pin_sync

`default_nettype wire

// File: verilog/host_cycle_timer.sv
// down counter that times every controller state except idle and retention hold
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"

module host_cycle_timer (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	// load a new count, done while the count is zero
	input  wire logic                   load_i,
	input  wire logic [`SRAM_TMR_W-1:0] load_val_i,
	output logic                        done_o
);

	logic [`SRAM_TMR_W-1:0] count_ff;
	logic [`SRAM_TMR_W-1:0] nxt_count;

	// load wins, otherwise count down and stop at zero
	always_comb begin
		if (load_i) begin
			nxt_count = load_val_i;
		end else if (count_ff != '0) begin
			nxt_count = count_ff - `SRAM_TMR_W'(1);
		end else begin
			nxt_count = count_ff;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign done_o = (count_ff == '0);

endmodule // host_cycle_timer

`default_nettype wire

// File: dv/sram_host_assertions.sv
// concurrent checks on the ports of the static memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"
module sram_host_assertions (
	// clock and reset
	input wire logic                      clock_i,
	input wire logic                      rst_n_i,
	// user side
	input wire logic                      req_valid_i,
	input wire sram_host_pkg::mem_req_s   req_i,
	input wire logic                      req_ready_o,
	input wire logic                      rsp_valid_o,
	input wire logic [`SRAM_DATA_W-1:0]   rsp_rdata_o,
	input wire logic                      wr_done_o,
	input wire logic                      retention_req_i,
	input wire logic                      retention_ack_o,
	// memory side
	input wire sram_host_pkg::sram_pins_s pins_o,
	input wire logic [`SRAM_DATA_W-1:0]   shared_data_bus_i
);
	logic tk;
	// a request is taken on this edge
	assign tk = req_valid_i && req_ready_o;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd_lat; tk && !req_i.write |-> ##18 $rose(rsp_valid_o); endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_wr_lat; tk && req_i.write |-> ##15 $rose(wr_done_o); endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write done late");
	property p_wr_pulse;
		tk && req_i.write |=> (!pins_o.we_n && !pins_o.cs_n)[*8]
			##1 (!pins_o.we_n && !pins_o.cs_n)[*4] ##1 (pins_o.we_n && pins_o.cs_n);
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse width");
	property p_wr_end;
		$rose(pins_o.we_n) |-> $rose(pins_o.cs_n) && pins_o.data_oe
			&& $stable(pins_o.data_out) && $stable(pins_o.word_address);
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end hold");
	property p_wr_start;
		$fell(pins_o.we_n) |-> $fell(pins_o.cs_n) && pins_o.oe_n && pins_o.data_oe;
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("write start");
	property p_no_clash; !pins_o.oe_n |-> !pins_o.data_oe; endproperty
	a_no_clash: assert property (p_no_clash) else $error("bus driven in read");
	property p_float; $rose(pins_o.oe_n) |-> (!pins_o.data_oe)[*5]; endproperty
	a_float: assert property (p_float) else $error("bus driven too soon");
	property p_rd_addr;
		!pins_o.oe_n && $past(!pins_o.oe_n) |-> $stable(pins_o.word_address);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read address moved");
	property p_ret; retention_ack_o |-> pins_o.cs_n && !req_ready_o; endproperty
	a_ret: assert property (p_ret) else $error("selected in retention");
	property p_ret_req;
		$rose(retention_ack_o) |-> pins_o.cs_n && $past(pins_o.cs_n) && !pins_o.data_oe
			&& !req_ready_o;
	endproperty
	a_ret_req: assert property (p_ret_req) else $error("not deselected before ack");
	property p_wake;
		$fell(retention_ack_o) |-> (!req_ready_o)[*8] ##1 (!req_ready_o)[*6];
	endproperty
	a_wake: assert property (p_wake) else $error("wake too short");
	property p_rdata_hold; !$rose(rsp_valid_o) |-> $stable(rsp_rdata_o); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved");
endmodule // sram_host_assertions
`default_nettype wire

// File: dv/sram_async_model.sv
// behavioural model of the asynchronous static memory on the far side
`timescale 1ns/1ps
`default_nettype none
module sram_async_model #(
	parameter int ACC_NS = 70,
	parameter int HZ_NS  = 20
) (
	// bench clock, for the floating bus pattern and the contention check
	input  wire logic                      clock_i,
	// pins from the host and the resolved bus
	input  wire sram_host_pkg::sram_pins_s pins_i,
	output logic [7:0]                     bus_o,
	output logic                           clash_o
);
	logic [7:0] mem [logic [18:0]];
	logic [7:0] dq;
	logic [7:0] pat;
	logic       drv;
	logic       wr_act;
	initial begin
		dq = 8'h00;
		pat = 8'h5A;
		drv = 1'b0;
		wr_act = 1'b0;
		clash_o = 1'b0;
	end
	// floating bus shows a pattern that changes every cycle
	always @(posedge clock_i) pat <= pat + 8'h3B;
	// store at end of overlap, drive only in read mode, ignore all when deselected
	always @(pins_i) begin
		if (wr_act && (pins_i.cs_n || pins_i.we_n)) mem[pins_i.word_address] = bus_o;
		wr_act = !pins_i.cs_n && !pins_i.we_n;
		if (!pins_i.cs_n && !pins_i.oe_n && pins_i.we_n) begin
			drv <= 1'b1;
			dq <= 8'hFF;
			dq <= #ACC_NS (mem.exists(pins_i.word_address) ? mem[pins_i.word_address] : 8'hC3);
		end else if (drv) begin
			drv <= #HZ_NS 1'b0;
		end
	end
	// wire level from both parties
	always_comb begin
		if (pins_i.data_oe) bus_o = pins_i.data_out;
		else if (drv) bus_o = dq;
		else bus_o = pat;
	end
	// both parties driving is contention
	always @(posedge clock_i) if (pins_i.data_oe && drv) clash_o <= 1'b1;
endmodule // sram_async_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"
module tb_top;
	logic clock_i, rst_n_i, req_valid_i, req_ready_o, rsp_valid_o, wr_done_o;
	logic retention_req_i, retention_ack_o, clash;
	logic [7:0] rsp_rdata_o, bus;
	sram_host_pkg::mem_req_s req_i;
	sram_host_pkg::sram_pins_s pins_o;
	logic [8:0] exp_q [$];
	logic [8:0] e;
	logic [7:0] ref_mem [logic [18:0]];
	logic [18:0] pool [4] = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555};
	logic [31:0] seed = 32'h2E4905B4;
	logic [31:0] r;
	int miscompares = 0;
	int comparisons = 0;
	int n;
	async_static_ram_host async_static_ram_host_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .wr_done_o(wr_done_o),
		.retention_req_i(retention_req_i), .retention_ack_o(retention_ack_o),
		.pins_o(pins_o), .shared_data_bus_i(bus));
	sram_async_model sram_async_model_i (.clock_i(clock_i), .pins_i(pins_o), .bus_o(bus),
		.clash_o(clash));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// hold a request until taken and note the expected answer
	task automatic put(input logic w, input logic [18:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clock_i);
		req_valid_i <= 1'b1;
		req_i <= '{write: w, addr: a, wdata: d};
		do begin
			@(posedge clock_i);
			k++;
		end while (req_ready_o !== 1'b1 && k < 200);
		// a request never taken counts as a mismatch
		if (req_ready_o !== 1'b1) miscompares++;
		if (w) ref_mem[a] = d;
		exp_q.push_back({w, w ? 8'h00 : ref_mem[a]});
		req_valid_i <= 1'b0;
	endtask
	// clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// answers are matched against the oldest note
	always @(posedge clock_i) begin
		if (rsp_valid_o === 1'b1 || wr_done_o === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
			check({wr_done_o, wr_done_o ? 8'h00 : rsp_rdata_o}, e);
		end
	end
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_i = '0;
		retention_req_i = 1'b0;
		repeat (2) @(posedge clock_i);
		check({pins_o.cs_n, pins_o.oe_n, pins_o.we_n, pins_o.data_oe}, 4'hE);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) put(1'b1, pool[i], 8'h5A ^ 8'(i * 8'h33));
		for (int i = 0; i < 4; i++) put(1'b0, pool[i], 8'h00);
		for (int i = 0; i < 24; i++) begin
			r = xs();
			put(r[0], pool[r[2:1]], r[15:8]);
		end
		@(posedge clock_i);
		retention_req_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (retention_ack_o !== 1'b1 && n < 100);
		check({retention_ack_o, pins_o.cs_n}, 2'h3);
		repeat (20) @(posedge clock_i);
		retention_req_i <= 1'b0;
		for (int i = 0; i < 4; i++) put(1'b0, pool[i], 8'h00);
		n = 0;
		while (exp_q.size() > 0 && n < 100) begin
			@(posedge clock_i);
			n++;
		end
		check(exp_q.size(), 0);
		check(clash, 1'b0);
		end_of_test();
	end
	// watchdog
	initial begin
		#20us;
		miscompares++;
		end_of_test();
	end
endmodule // tb_top
bind async_static_ram_host sram_host_assertions sram_host_assertions_i (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
	.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
	.wr_done_o(wr_done_o), .retention_req_i(retention_req_i),
	.retention_ack_o(retention_ack_o), .pins_o(pins_o),
	.shared_data_bus_i(shared_data_bus_i));
`default_nettype wire
